// *** haptic_wave_sequencer_cfg_consts.svh ***
// Named constants for the haptic wave sequencer configuration block
`ifndef HAPTIC_WAVE_SEQUENCER_CFG_CONSTS_SVH
`define HAPTIC_WAVE_SEQUENCER_CFG_CONSTS_SVH
// Register offsets on the serial control bus
`define HW_OFF_SLOT7        8'h10
`define HW_OFF_SLOT8        8'h11
`define HW_OFF_REP12        8'h12
`define HW_OFF_REP34        8'h13
`define HW_OFF_REP56        8'h14
`define HW_OFF_REP78        8'h15
`define HW_OFF_PAUSE_OUTER  8'h16
`define HW_OFF_CONT_CTL     8'h18
`define HW_OFF_PRESET_RES   8'h19
`define HW_OFF_HALF_CYCLE   8'h1A
// Reset values
`define HW_RST_SLOT         8'h00
`define HW_RST_REPEAT       8'h00
`define HW_RST_PAUSE_OUTER  8'h00
`define HW_RST_CONT_CTL     8'h10
`define HW_RST_PRESET_RES   8'h8D
`define HW_RST_HALF_CYCLE   8'h6A
`define HW_RD_UNMAPPED      8'h00
// Writable bit masks, unused bits read zero
`define HW_MASK_PAUSE_OUTER 8'h3F
`define HW_MASK_CONT_CTL    8'hF0
// Field positions
`define HW_SLOT_PAUSE_BIT   7
`define HW_OPEN_LOOP_BIT    7
`define HW_BRAKE_FOLLOW_BIT 6
`define HW_RES_DET_BIT      5
`define HW_EDGE_SHAPE_BIT   4
`define HW_PAUSE_SEL_MSB    5
`define HW_PAUSE_SEL_LSB    4
`define HW_OUTER_MSB        3
// Sequencer constants
`define HW_REPEAT_FOREVER   4'hF
`define HW_LAST_SLOT        3'h7
`define HW_UNIT_LEN_1       10'h001
`define HW_UNIT_LEN_8       10'h008
`define HW_UNIT_LEN_64      10'h040
`define HW_UNIT_LEN_512     10'h200
`define HW_MODE_MEMORY      2'h0
`define HW_MODE_REALTIME    2'h1
`define HW_MODE_CONT        2'h2
// Timing: system clock and waveform data rates
`define HW_CLK_HZ           250_000_000
`define HW_RATE_8K_HZ       8_000
`define HW_RATE_12K_HZ      12_000
`define HW_RATE_24K_HZ      24_000
`define HW_RATE_48K_HZ      48_000
`define HW_RATE_SEL_8K      2'h0
`define HW_RATE_SEL_12K     2'h1
`define HW_RATE_SEL_24K     2'h2
// Serial bus
`define HW_BITS_PER_BYTE    4'h8
`define HW_I2C_ADDR_DEFAULT 7'h2A
`endif

// *** haptic_wave_sequencer_pkg.sv ***
// Types shared by the haptic wave sequencer configuration block
`default_nettype none
package haptic_wave_sequencer_pkg;
  typedef enum logic [7:0] {
    I2C_IDLE  = 8'h01, I2C_ADDR  = 8'h02, I2C_AACK  = 8'h04, I2C_PTR  = 8'h08,
    I2C_PACK  = 8'h10, I2C_WDATA = 8'h20, I2C_WACK  = 8'h40, I2C_RDATA = 8'h80
  } i2c_state_t;
  typedef enum logic [5:0] {
    SEQ_IDLE = 6'h01, SEQ_LOAD = 6'h02, SEQ_WAVE = 6'h04,
    SEQ_PAUSE = 6'h08, SEQ_NEXT = 6'h10, SEQ_OUTER = 6'h20
  } seq_state_t;
  typedef struct packed {
    logic scl_s1; logic scl_s2; logic scl_d;
    logic sda_s1; logic sda_s2; logic sda_d;
  } sync_t;
  typedef struct packed {
    i2c_state_t  state;
    logic [3:0]  bit_cnt;
    logic [7:0]  shift;
    logic [7:0]  ptr;
    logic        rd;
    logic        in_ack;
    logic        sda_oe_n;
    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [7:0]  wr_data;
  } i2c_t;
  typedef struct packed {
    logic [7:0] slot7; logic [7:0] slot8;
    logic [7:0] rep12; logic [7:0] rep34; logic [7:0] rep56; logic [7:0] rep78;
    logic [7:0] pause_outer; logic [7:0] cont_ctl;
    logic [7:0] preset_res; logic [7:0] half_cycle;
  } regs_t;
  typedef struct packed {
    seq_state_t  state;
    logic [2:0]  slot;
    logic [3:0]  rep_cnt;
    logic [3:0]  outer_cnt;
    logic [6:0]  pause_cnt;
    logic [9:0]  unit_cnt;
    logic [15:0] div_cnt;
    logic        wave_start;
    logic [6:0]  wave_num;
  } seq_t;
  typedef struct packed {
    logic zero_cross_en; logic brake_boost; logic fixed_half;
    logic rtp_start; logic cont_start; logic halt;
  } ctl_t;
endpackage
`default_nettype wire

// *** haptic_wave_sequencer_cfg.sv ***
// Register bank, serial bus slave and memory playback sequencer
`timescale 1ns/10ps
`default_nettype none
`include "haptic_wave_sequencer_cfg_consts.svh"
module haptic_wave_sequencer_cfg #(
  parameter logic [6:0]  DEV_ADDR = `HW_I2C_ADDR_DEFAULT,
  parameter logic [15:0] DIV_8K   = 16'(`HW_CLK_HZ / `HW_RATE_8K_HZ),
  parameter logic [15:0] DIV_12K  = 16'(`HW_CLK_HZ / `HW_RATE_12K_HZ),
  parameter logic [15:0] DIV_24K  = 16'(`HW_CLK_HZ / `HW_RATE_24K_HZ),
  parameter logic [15:0] DIV_48K  = 16'(`HW_CLK_HZ / `HW_RATE_48K_HZ)
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output var  logic        o_sda_out,
  output var  logic        o_sda_oe_n,
  input  wire logic        i_play_go,
  input  wire logic        i_play_halt,
  input  wire logic [1:0]  i_play_mode,
  input  wire logic        i_track_en,
  input  wire logic [1:0]  i_wave_rate_select,
  input  wire logic        i_boost_mode,
  input  wire logic [47:0] i_slots_1_6,
  input  wire logic        i_wave_done,
  output var  logic        o_wave_start,
  output var  logic [6:0]  o_wave_num,
  output var  logic        o_seq_busy,
  output var  logic        o_rtp_start,
  output var  logic        o_cont_start,
  output var  logic        o_halt,
  output var  logic        o_open_loop,
  output var  logic        o_zero_cross_en,
  output var  logic        o_brake_boost_mode,
  output var  logic        o_resonance_detect_en,
  output var  logic        o_edge_shape_cos,
  output var  logic [7:0]  o_preset_resonance,
  output var  logic [7:0]  o_half_cycle_drive_len,
  output var  logic        o_fixed_half_cycle
);
  haptic_wave_sequencer_pkg::sync_t sync_ff, nxt_sync;
  haptic_wave_sequencer_pkg::i2c_t  i2c_ff,  nxt_i2c;
  haptic_wave_sequencer_pkg::regs_t regs_ff, nxt_regs;
  haptic_wave_sequencer_pkg::seq_t  seq_ff,  nxt_seq;
  haptic_wave_sequencer_pkg::ctl_t  ctl_ff,  nxt_ctl;
  logic        scl_rise, scl_fall, bus_start, bus_stop;
  logic [7:0]  rd_data, slot_cfg;
  logic [31:0] rep_vec;
  logic [3:0]  slot_rep, outer_code;
  logic [15:0] div_len;
  logic [9:0]  unit_len;

  // Register read mux; unmapped offsets read zero
  function automatic logic [7:0] reg_read(input haptic_wave_sequencer_pkg::regs_t r,
                                          input logic [7:0] a);
    case (a)
      `HW_OFF_SLOT7:       reg_read = r.slot7;
      `HW_OFF_SLOT8:       reg_read = r.slot8;
      `HW_OFF_REP12:       reg_read = r.rep12;
      `HW_OFF_REP34:       reg_read = r.rep34;
      `HW_OFF_REP56:       reg_read = r.rep56;
      `HW_OFF_REP78:       reg_read = r.rep78;
      `HW_OFF_PAUSE_OUTER: reg_read = r.pause_outer;
      `HW_OFF_CONT_CTL:    reg_read = r.cont_ctl;
      `HW_OFF_PRESET_RES:  reg_read = r.preset_res;
      `HW_OFF_HALF_CYCLE:  reg_read = r.half_cycle;
      default:             reg_read = `HW_RD_UNMAPPED;
    endcase
  endfunction

  // Bus pins pass two flops; edge detect compares the second stage with a third delay flop
  always_comb begin
    nxt_sync.scl_s1 = i_scl;
    nxt_sync.scl_s2 = sync_ff.scl_s1;
    nxt_sync.scl_d  = sync_ff.scl_s2;
    nxt_sync.sda_s1 = i_sda;
    nxt_sync.sda_s2 = sync_ff.sda_s1;
    nxt_sync.sda_d  = sync_ff.sda_s2;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync_ff <= '1;
    end else begin
      sync_ff <= nxt_sync;
    end
  end

  assign scl_rise  = sync_ff.scl_s2 & ~sync_ff.scl_d;
  assign scl_fall  = ~sync_ff.scl_s2 & sync_ff.scl_d;
  assign bus_start = sync_ff.scl_s2 & sync_ff.scl_d & sync_ff.sda_d & ~sync_ff.sda_s2;
  assign bus_stop  = sync_ff.scl_s2 & sync_ff.scl_d & ~sync_ff.sda_d & sync_ff.sda_s2;
  assign rd_data   = reg_read(regs_ff, i2c_ff.ptr);

  // Serial slave: sample on SCL rise, change SDA on SCL fall
  always_comb begin
    nxt_i2c       = i2c_ff;
    nxt_i2c.wr_en = 1'b0;
    if (bus_start) begin
      nxt_i2c.state    = haptic_wave_sequencer_pkg::I2C_ADDR;
      nxt_i2c.bit_cnt  = '0;
      nxt_i2c.sda_oe_n = 1'b1;
    end else if (bus_stop) begin
      nxt_i2c.state    = haptic_wave_sequencer_pkg::I2C_IDLE;
      nxt_i2c.sda_oe_n = 1'b1;
    end else if (scl_rise) begin
      if (i2c_ff.state == haptic_wave_sequencer_pkg::I2C_RDATA && i2c_ff.in_ack) begin
        nxt_i2c.rd = ~sync_ff.sda_s2; // Master nack ends the read burst
      end else if (i2c_ff.state inside {haptic_wave_sequencer_pkg::I2C_ADDR,
                   haptic_wave_sequencer_pkg::I2C_PTR, haptic_wave_sequencer_pkg::I2C_WDATA})
      begin
        nxt_i2c.shift   = {i2c_ff.shift[6:0], sync_ff.sda_s2};
        nxt_i2c.bit_cnt = i2c_ff.bit_cnt + 4'h1;
      end
    end else if (scl_fall) begin
      case (i2c_ff.state)
        haptic_wave_sequencer_pkg::I2C_ADDR: begin
          if (i2c_ff.bit_cnt == `HW_BITS_PER_BYTE) begin
            nxt_i2c.bit_cnt = '0;
            if (i2c_ff.shift[7:1] == DEV_ADDR) begin
              nxt_i2c.state    = haptic_wave_sequencer_pkg::I2C_AACK;
              nxt_i2c.rd       = i2c_ff.shift[0];
              nxt_i2c.sda_oe_n = 1'b0;
            end else begin
              nxt_i2c.state = haptic_wave_sequencer_pkg::I2C_IDLE;
            end
          end
        end
        haptic_wave_sequencer_pkg::I2C_PTR: begin
          if (i2c_ff.bit_cnt == `HW_BITS_PER_BYTE) begin
            nxt_i2c.bit_cnt  = '0;
            nxt_i2c.ptr      = i2c_ff.shift;
            nxt_i2c.state    = haptic_wave_sequencer_pkg::I2C_PACK;
            nxt_i2c.sda_oe_n = 1'b0;
          end
        end
        haptic_wave_sequencer_pkg::I2C_WDATA: begin
          if (i2c_ff.bit_cnt == `HW_BITS_PER_BYTE) begin
            nxt_i2c.bit_cnt  = '0;
            nxt_i2c.wr_en    = 1'b1;
            nxt_i2c.wr_addr  = i2c_ff.ptr;
            nxt_i2c.wr_data  = i2c_ff.shift;
            nxt_i2c.ptr      = i2c_ff.ptr + 8'h01;
            nxt_i2c.state    = haptic_wave_sequencer_pkg::I2C_WACK;
            nxt_i2c.sda_oe_n = 1'b0;
          end
        end
        haptic_wave_sequencer_pkg::I2C_AACK, haptic_wave_sequencer_pkg::I2C_PACK,
        haptic_wave_sequencer_pkg::I2C_WACK: begin
          nxt_i2c.sda_oe_n = 1'b1;
          nxt_i2c.state    = haptic_wave_sequencer_pkg::I2C_WDATA;
          if (i2c_ff.state == haptic_wave_sequencer_pkg::I2C_AACK) begin
            if (i2c_ff.rd) begin
              // Read burst starts at the stored pointer and post-increments
              nxt_i2c.state    = haptic_wave_sequencer_pkg::I2C_RDATA;
              nxt_i2c.shift    = rd_data;
              nxt_i2c.ptr      = i2c_ff.ptr + 8'h01;
              nxt_i2c.in_ack   = 1'b0;
              nxt_i2c.sda_oe_n = rd_data[7];
            end else begin
              nxt_i2c.state = haptic_wave_sequencer_pkg::I2C_PTR;
            end
          end
        end
        haptic_wave_sequencer_pkg::I2C_RDATA: begin
          if (i2c_ff.in_ack) begin
            if (i2c_ff.rd) begin
              nxt_i2c.shift    = rd_data;
              nxt_i2c.ptr      = i2c_ff.ptr + 8'h01;
              nxt_i2c.in_ack   = 1'b0;
              nxt_i2c.sda_oe_n = rd_data[7];
            end else begin
              nxt_i2c.state = haptic_wave_sequencer_pkg::I2C_IDLE;
            end
          end else if (i2c_ff.bit_cnt == `HW_BITS_PER_BYTE - 4'h1) begin
            nxt_i2c.bit_cnt  = '0;
            nxt_i2c.in_ack   = 1'b1;
            nxt_i2c.sda_oe_n = 1'b1; // Release for the master acknowledge
          end else begin
            nxt_i2c.bit_cnt  = i2c_ff.bit_cnt + 4'h1;
            nxt_i2c.shift    = {i2c_ff.shift[6:0], 1'b0};
            nxt_i2c.sda_oe_n = i2c_ff.shift[6];
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      i2c_ff       <= '0;
      i2c_ff.state <= haptic_wave_sequencer_pkg::I2C_IDLE;
      i2c_ff.sda_oe_n <= 1'b1;
    end else begin
      i2c_ff <= nxt_i2c;
    end
  end

  // Register writes one cycle after the data byte is taken
  always_comb begin
    nxt_regs = regs_ff;
    if (i2c_ff.wr_en) begin
      case (i2c_ff.wr_addr)
        `HW_OFF_SLOT7:       nxt_regs.slot7       = i2c_ff.wr_data;
        `HW_OFF_SLOT8:       nxt_regs.slot8       = i2c_ff.wr_data;
        `HW_OFF_REP12:       nxt_regs.rep12       = i2c_ff.wr_data;
        `HW_OFF_REP34:       nxt_regs.rep34       = i2c_ff.wr_data;
        `HW_OFF_REP56:       nxt_regs.rep56       = i2c_ff.wr_data;
        `HW_OFF_REP78:       nxt_regs.rep78       = i2c_ff.wr_data;
        `HW_OFF_PAUSE_OUTER: nxt_regs.pause_outer = i2c_ff.wr_data & `HW_MASK_PAUSE_OUTER;
        `HW_OFF_CONT_CTL:    nxt_regs.cont_ctl    = i2c_ff.wr_data & `HW_MASK_CONT_CTL;
        `HW_OFF_PRESET_RES:  nxt_regs.preset_res  = i2c_ff.wr_data;
        `HW_OFF_HALF_CYCLE:  nxt_regs.half_cycle  = i2c_ff.wr_data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      regs_ff <= '{`HW_RST_SLOT, `HW_RST_SLOT, `HW_RST_REPEAT, `HW_RST_REPEAT,
                   `HW_RST_REPEAT, `HW_RST_REPEAT, `HW_RST_PAUSE_OUTER,
                   `HW_RST_CONT_CTL, `HW_RST_PRESET_RES, `HW_RST_HALF_CYCLE};
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  // Slot selection, repeat codes and pause timing
  always_comb begin
    slot_cfg = (seq_ff.slot == `HW_LAST_SLOT) ? regs_ff.slot8 :
               (seq_ff.slot == `HW_LAST_SLOT - 3'h1) ? regs_ff.slot7 :
               i_slots_1_6[{seq_ff.slot, 3'b000} +: 8];
    rep_vec  = {regs_ff.rep78[3:0], regs_ff.rep78[7:4], regs_ff.rep56[3:0],
                regs_ff.rep56[7:4], regs_ff.rep34[3:0], regs_ff.rep34[7:4],
                regs_ff.rep12[3:0], regs_ff.rep12[7:4]};
    slot_rep   = rep_vec[{seq_ff.slot, 2'b00} +: 4];
    outer_code = regs_ff.pause_outer[`HW_OUTER_MSB:0];
    case (i_wave_rate_select)
      `HW_RATE_SEL_8K:  div_len = DIV_8K;
      `HW_RATE_SEL_12K: div_len = DIV_12K;
      `HW_RATE_SEL_24K: div_len = DIV_24K;
      default:          div_len = DIV_48K;
    endcase
    case (regs_ff.pause_outer[`HW_PAUSE_SEL_MSB:`HW_PAUSE_SEL_LSB])
      2'h0:    unit_len = `HW_UNIT_LEN_1;
      2'h1:    unit_len = `HW_UNIT_LEN_8;
      2'h2:    unit_len = `HW_UNIT_LEN_64;
      default: unit_len = `HW_UNIT_LEN_512;
    endcase
  end

  // Memory playback sequencer; halt has priority over everything
  always_comb begin
    nxt_seq            = seq_ff;
    nxt_seq.wave_start = 1'b0;
    if (i_play_halt) begin
      nxt_seq.state = haptic_wave_sequencer_pkg::SEQ_IDLE;
    end else begin
      case (seq_ff.state)
        haptic_wave_sequencer_pkg::SEQ_IDLE: begin
          if (i_play_go && i_play_mode == `HW_MODE_MEMORY) begin
            nxt_seq.state     = haptic_wave_sequencer_pkg::SEQ_LOAD;
            nxt_seq.slot      = '0;
            nxt_seq.rep_cnt   = '0;
            nxt_seq.outer_cnt = '0;
          end
        end
        haptic_wave_sequencer_pkg::SEQ_LOAD: begin
          if (slot_cfg[`HW_SLOT_PAUSE_BIT]) begin
            nxt_seq.state     = haptic_wave_sequencer_pkg::SEQ_PAUSE;
            nxt_seq.pause_cnt = slot_cfg[6:0];
            nxt_seq.unit_cnt  = '0;
            nxt_seq.div_cnt   = '0;
          end else if (slot_cfg[6:0] == 7'h00) begin
            nxt_seq.state = haptic_wave_sequencer_pkg::SEQ_OUTER; // Empty slot ends the pass
          end else begin
            nxt_seq.state      = haptic_wave_sequencer_pkg::SEQ_WAVE;
            nxt_seq.wave_start = 1'b1;
            nxt_seq.wave_num   = slot_cfg[6:0];
          end
        end
        haptic_wave_sequencer_pkg::SEQ_WAVE: begin
          if (i_wave_done) begin
            nxt_seq.state = haptic_wave_sequencer_pkg::SEQ_NEXT;
          end
        end
        haptic_wave_sequencer_pkg::SEQ_PAUSE: begin
          // Code times unit, unit counted in data-rate samples
          if (seq_ff.pause_cnt == 7'h00) begin
            nxt_seq.state = haptic_wave_sequencer_pkg::SEQ_NEXT;
          end else if (seq_ff.div_cnt == div_len - 16'h0001) begin
            nxt_seq.div_cnt = '0;
            if (seq_ff.unit_cnt == unit_len - 10'h001) begin
              nxt_seq.unit_cnt  = '0;
              nxt_seq.pause_cnt = seq_ff.pause_cnt - 7'h01;
            end else begin
              nxt_seq.unit_cnt = seq_ff.unit_cnt + 10'h001;
            end
          end else begin
            nxt_seq.div_cnt = seq_ff.div_cnt + 16'h0001;
          end
        end
        haptic_wave_sequencer_pkg::SEQ_NEXT: begin
          nxt_seq.state = haptic_wave_sequencer_pkg::SEQ_LOAD;
          if (slot_rep == `HW_REPEAT_FOREVER) begin
            nxt_seq.rep_cnt = seq_ff.rep_cnt;
          end else if (seq_ff.rep_cnt < slot_rep) begin
            nxt_seq.rep_cnt = seq_ff.rep_cnt + 4'h1;
          end else begin
            nxt_seq.rep_cnt = '0;
            if (seq_ff.slot == `HW_LAST_SLOT) begin
              nxt_seq.state = haptic_wave_sequencer_pkg::SEQ_OUTER;
            end else begin
              nxt_seq.slot = seq_ff.slot + 3'h1;
            end
          end
        end
        haptic_wave_sequencer_pkg::SEQ_OUTER: begin
          nxt_seq.slot    = '0;
          nxt_seq.rep_cnt = '0;
          nxt_seq.state   = haptic_wave_sequencer_pkg::SEQ_LOAD;
          if (outer_code == `HW_REPEAT_FOREVER) begin
            nxt_seq.outer_cnt = seq_ff.outer_cnt;
          end else if (seq_ff.outer_cnt < outer_code) begin
            nxt_seq.outer_cnt = seq_ff.outer_cnt + 4'h1;
          end else begin
            nxt_seq.state = haptic_wave_sequencer_pkg::SEQ_IDLE;
          end
        end
        default: nxt_seq.state = haptic_wave_sequencer_pkg::SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      seq_ff       <= '0;
      seq_ff.state <= haptic_wave_sequencer_pkg::SEQ_IDLE;
    end else begin
      seq_ff <= nxt_seq;
    end
  end

  // Derived drive controls and mode start pulses
  always_comb begin
    nxt_ctl.zero_cross_en = ~regs_ff.cont_ctl[`HW_OPEN_LOOP_BIT];
    nxt_ctl.brake_boost   = regs_ff.cont_ctl[`HW_BRAKE_FOLLOW_BIT] & i_boost_mode;
    nxt_ctl.fixed_half    = ~i_track_en;
    nxt_ctl.halt          = i_play_halt;
    nxt_ctl.rtp_start     = i_play_go & ~i_play_halt & (i_play_mode == `HW_MODE_REALTIME);
    nxt_ctl.cont_start    = i_play_go & ~i_play_halt & (i_play_mode == `HW_MODE_CONT);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctl_ff <= '0;
      ctl_ff.zero_cross_en <= 1'b1;
    end else begin
      ctl_ff <= nxt_ctl;
    end
  end

  // Outputs straight from flops; SDA is open drain, only ever pulled low
  assign o_sda_out              = 1'b0;
  assign o_sda_oe_n             = i2c_ff.sda_oe_n;
  assign o_wave_start           = seq_ff.wave_start;
  assign o_wave_num             = seq_ff.wave_num;
  assign o_seq_busy             = ~seq_ff.state[0];
  assign o_rtp_start            = ctl_ff.rtp_start;
  assign o_cont_start           = ctl_ff.cont_start;
  assign o_halt                 = ctl_ff.halt;
  assign o_open_loop            = regs_ff.cont_ctl[`HW_OPEN_LOOP_BIT];
  assign o_zero_cross_en        = ctl_ff.zero_cross_en;
  assign o_brake_boost_mode     = ctl_ff.brake_boost;
  assign o_resonance_detect_en  = regs_ff.cont_ctl[`HW_RES_DET_BIT];
  assign o_edge_shape_cos       = regs_ff.cont_ctl[`HW_EDGE_SHAPE_BIT];
  assign o_preset_resonance     = regs_ff.preset_res;
  assign o_half_cycle_drive_len = regs_ff.half_cycle;
  assign o_fixed_half_cycle     = ctl_ff.fixed_half;
endmodule
`default_nettype wire

// *** hws_cfg_asserts.sv ***
// Port assertions for the haptic wave sequencer configuration block
`timescale 1ns/10ps
`default_nettype none
module hws_cfg_asserts (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       i_play_go,
  input wire logic       i_play_halt,
  input wire logic [1:0] i_play_mode,
  input wire logic       i_track_en,
  input wire logic       i_boost_mode,
  input wire logic       o_wave_start,
  input wire logic [6:0] o_wave_num,
  input wire logic       o_seq_busy,
  input wire logic       o_rtp_start,
  input wire logic       o_cont_start,
  input wire logic       o_halt,
  input wire logic       o_open_loop,
  input wire logic       o_zero_cross_en,
  input wire logic       o_brake_boost_mode,
  input wire logic       o_fixed_half_cycle
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // A halt in the same cycle wins over a go
  wire logic go_ok = i_play_go && !i_play_halt;
  sequence s_halted; o_halt && !o_seq_busy; endsequence
  sequence s_pulse; o_wave_start ##1 !o_wave_start; endsequence
  property p_halt; i_play_halt |=> s_halted; endproperty
  property p_go; go_ok && i_play_mode == 2'h0 && !o_seq_busy |=> o_seq_busy; endproperty
  property p_rtp; go_ok && i_play_mode == 2'h1 |=> o_rtp_start; endproperty
  property p_cont; go_ok && i_play_mode == 2'h2 |=> o_cont_start; endproperty
  property p_zc; o_zero_cross_en == !$past(o_open_loop); endproperty
  property p_brk; o_brake_boost_mode |-> $past(i_boost_mode); endproperty
  property p_fix; o_fixed_half_cycle == !$past(i_track_en); endproperty
  property p_ws; o_wave_start |-> o_seq_busy ##0 s_pulse; endproperty
  property p_num; !o_wave_start |-> $stable(o_wave_num); endproperty
  a_halt: assert property (p_halt) else $error("halt not honoured");
  a_go: assert property (p_go) else $error("memory go not taken");
  a_rtp: assert property (p_rtp) else $error("real-time start missing");
  a_cont: assert property (p_cont) else $error("continuous start missing");
  a_zc: assert property (p_zc) else $error("zero-crossing enable wrong");
  a_brk: assert property (p_brk) else $error("brake boost without boost mode");
  a_fix: assert property (p_fix) else $error("fixed half cycle wrong");
  a_ws: assert property (p_ws) else $error("wave start not a lone pulse");
  a_num: assert property (p_num) else $error("wave number moved");
endmodule
bind haptic_wave_sequencer_cfg hws_cfg_asserts hws_cfg_asserts_i (.i_clk(i_clk), .i_rst(i_rst),
  .i_play_go(i_play_go), .i_play_halt(i_play_halt), .i_play_mode(i_play_mode),
  .i_track_en(i_track_en), .i_boost_mode(i_boost_mode), .o_wave_start(o_wave_start),
  .o_wave_num(o_wave_num), .o_seq_busy(o_seq_busy), .o_rtp_start(o_rtp_start),
  .o_cont_start(o_cont_start), .o_halt(o_halt), .o_open_loop(o_open_loop),
  .o_zero_cross_en(o_zero_cross_en), .o_brake_boost_mode(o_brake_boost_mode),
  .o_fixed_half_cycle(o_fixed_half_cycle));
`default_nettype wire

// *** haptic_wave_sequencer_cfg_tb_top.sv ***
// Self-checking testbench for the haptic wave sequencer configuration block
`timescale 1ns/10ps
`default_nettype none
module haptic_wave_sequencer_cfg_tb_top;
  localparam logic [7:0] ADR [11] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17,
    8'h18, 8'h19, 8'h1A};
  localparam logic [7:0] RSV [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h10, 8'h8D, 8'h6A};
  localparam logic [7:0] MSK [11] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h00,
    8'hF0, 8'hFF, 8'hFF};
  localparam logic [7:0] SEQ [7] = '{8'h83, 8'h09, 8'h00, 8'h00, 8'h00, 8'h01, 8'h10};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        scl = 1'b1;
  logic        sdm = 1'b1;
  logic        go = 1'b0;
  logic        halt = 1'b0;
  logic        done = 1'b0;
  logic        trk = 1'b1;
  logic        bm = 1'b1;
  logic [1:0]  mode = 2'h0;
  logic [47:0] s16 = 48'h0000_0000_0000;
  logic [7:0]  rb;
  int          miscompares = 0;
  int          checks_done = 0;
  int          starts = 0;
  int          cyc = 0;
  int          t0 = 0;
  int          t1 = 0;
  wire logic       oe_n, ws, busy, ol, zc, rde, ec, bb, fx, rs, cs, oh;
  wire logic [6:0] wnum;
  wire logic [7:0] pr, hc;
  // Open-drain data line with pull-up
  wire logic       sda = sdm & oe_n;
  haptic_wave_sequencer_cfg #(.DIV_8K(16'h0004), .DIV_12K(16'h0004), .DIV_24K(16'h0004),
    .DIV_48K(16'h0004)) haptic_wave_sequencer_cfg_i (.i_clk(clk), .i_rst(rst), .i_scl(scl),
    .i_sda(sda), .o_sda_out(), .o_sda_oe_n(oe_n), .i_play_go(go), .i_play_halt(halt),
    .i_play_mode(mode), .i_track_en(trk), .i_wave_rate_select(2'h0), .i_boost_mode(bm),
    .i_slots_1_6(s16), .i_wave_done(done), .o_wave_start(ws), .o_wave_num(wnum),
    .o_seq_busy(busy), .o_rtp_start(rs), .o_cont_start(cs), .o_halt(oh), .o_open_loop(ol),
    .o_zero_cross_en(zc), .o_brake_boost_mode(bb), .o_resonance_detect_en(rde),
    .o_edge_shape_cos(ec), .o_preset_resonance(pr), .o_half_cycle_drive_len(hc),
    .o_fixed_half_cycle(fx));
  always #2 clk = ~clk;
  // Player stand-in: finishes each waveform one cycle after its start
  always @(negedge clk) begin
    cyc <= cyc + 1;
    done <= ws;
    if (ws === 1'b1 && starts == 0) t1 <= cyc;
    if (ws === 1'b1) starts <= starts + 1;
  end
  task automatic wt(input int n); repeat (n) @(negedge clk); endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  // Start when b is 0 (leaves SCL low), stop when b is 1
  task automatic cnd(input logic a, input logic b);
    sdm = a;
    wt(4);
    scl = 1'b1;
    wt(8);
    sdm = b;
    wt(8);
    scl = b;
    wt(4);
  endtask
  task automatic bitx(input logic b, output logic r);
    sdm = b;
    wt(8);
    scl = 1'b1;
    wt(8);
    r = sda;
    scl = 1'b0;
    wt(2);
  endtask
  // Ninth bit is released: slave ACK on writes, master NACK on reads
  task automatic byt(input logic [7:0] d, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(1'b1, a);
  endtask
  task automatic acc(input logic [7:0] ad, input logic [7:0] d, input logic rd);
    logic [7:0] q;
    logic       a0, a1;
    cnd(1'b1, 1'b0);
    byt({7'h2A, 1'b0}, q, a0);
    byt(ad, q, a1);
    if (rd) cnd(1'b1, 1'b0);
    if (rd) byt({7'h2A, 1'b1}, q, a1);
    byt(rd ? 8'hFF : d, rb, a1);
    cnd(1'b0, 1'b1);
    chk({7'h00, a0}, 8'h00);
  endtask
  task automatic kick();
    starts = 0;
    go = 1'b1;
    wt(1);
    go = 1'b0;
    t0 = cyc;
    wt(2);
  endtask
  task automatic play(input logic [6:0] num, input int n);
    kick();
    for (int k = 0; k < 3000 && busy !== 1'b0; k++) wt(1);
    chk({7'h00, busy}, 8'h00);
    chk(8'(starts), 8'(n));
    chk({1'b0, wnum}, {1'b0, num});
  endtask
  task automatic close_out();
    if (miscompares == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    wt(60000);
    miscompares++;
    close_out();
  end
  initial begin
    wt(5);
    rst = 1'b0;
    wt(4);
    chk({2'h0, ol, zc, rde, ec, bb, fx}, 8'h14);
    chk(pr, 8'h8D);
    chk(hc, 8'h6A);
    for (int k = 0; k < 11; k++) begin
      acc(ADR[k], 8'h00, 1'b1);
      chk(rb, RSV[k]);
    end
    for (int k = 0; k < 11; k++) acc(ADR[k], 8'hFF, 1'b0);
    for (int k = 0; k < 11; k++) begin
      acc(ADR[k], 8'h00, 1'b1);
      chk(rb, MSK[k]);
    end
    chk({2'h0, ol, zc, rde, ec, bb, fx}, 8'h2E);
    chk(pr, 8'hFF);
    chk(hc, 8'hFF);
    acc(8'h1A, 8'h70, 1'b0);
    chk(hc, 8'h70);
    bm = 1'b0;
    wt(2);
    chk({2'h0, ol, zc, rde, ec, bb, fx}, 8'h2C);
    acc(8'h18, 8'h00, 1'b0);
    trk = 1'b0;
    wt(2);
    chk({2'h0, ol, zc, rde, ec, bb, fx}, 8'h11);
    // Slot 1 three times, slot 2 ends the pass, two passes
    s16 = 48'h0000_0000_0005;
    acc(8'h12, 8'h20, 1'b0);
    acc(8'h16, 8'h01, 1'b0);
    play(7'h05, 6);
    // Empty pauses, slot 7 pauses 3 units of 8 samples, slot 8 plays twice
    s16 = 48'h8080_8080_8080;
    for (int k = 0; k < 7; k++) acc(8'(8'h10 + k), SEQ[k], 1'b0);
    play(7'h09, 2);
    chk(8'(t1 - t0 >= 96 && t1 - t0 < 140), 8'h01);
    // Endless slot repeat ends only on halt
    acc(8'h15, 8'h0F, 1'b0);
    kick();
    wt(300);
    chk(8'(busy === 1'b1 && starts > 3), 8'h01);
    halt = 1'b1;
    wt(1);
    chk({7'h00, oh}, 8'h01);
    halt = 1'b0;
    wt(2);
    chk({7'h00, busy}, 8'h00);
    for (int m = 1; m < 3; m++) begin
      mode = 2'(m);
      go = 1'b1;
      wt(1);
      go = 1'b0;
      chk({6'h00, cs, rs}, 8'(m));
      wt(2);
    end
    close_out();
  end
endmodule
`default_nettype wire
